// ### dv/ppx_page_ext_sva.sv
`timescale 1ns/100ps
module ppx_page_ext_chk #(
  parameter PAGE_W = 6
) (
  // clock, reset and requests
  input wire              i_clk,
  input wire              i_srst,
  input wire              i_reg_rd,
  input wire              i_call_start,
  input wire              i_rtc_start,
  input wire              i_call_indirect,
  input wire [PAGE_W-1:0] i_call_imm_page,
  input wire [PAGE_W-1:0] i_call_ind_page,
  input wire [15:0]       i_call_ret_addr,
  input wire [15:0]       i_core_addr,
  input wire              i_expanded_mode,
  input wire              i_emulate_port_k,
  input wire [1:0]        i_flash_alloc,
  input wire              i_rom_half_map,
  input wire [7:0]        i_gpio_port_k_out,
  // watched outputs
  input wire [7:0]        o_port_k_out,
  input wire [PAGE_W-1:0] o_reg_rdata,
  input wire              o_push,
  input wire              o_pull,
  input wire [15:0]       o_push_data,
  input wire              o_pc_load,
  input wire              o_queue_refill,
  input wire              o_seq_busy,
  input wire              o_irq_block,
  input wire [PAGE_W-1:0] o_program_page_select
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // pins carry bus information only in this mode
  wire ext_on = i_expanded_mode & i_emulate_port_k;
  wire call_go = i_call_start & ~o_seq_busy;

  a_win_xaddr: assert property (ext_on && i_core_addr[15:14] == 2'h2 |=>
    o_port_k_out[5:0] == $past(o_program_page_select)) else $error("window address wrong");
  a_const_xaddr: assert property (ext_on && i_core_addr[15:14] != 2'h2 |=> o_port_k_out[5:0] ==
    ($past(i_core_addr[15]) ? 6'h3F : ($past(i_core_addr[14]) ? 6'h3E : 6'h3D))) else $error("range constant wrong");
  a_sel_zero: assert property (ext_on && i_flash_alloc == 2'h0 |=>
    o_port_k_out[7] == !$past(i_core_addr[15])) else $error("select wrong at 0K");
  a_sel_16k: assert property (ext_on && i_flash_alloc == 2'h1 |=>
    o_port_k_out[7] == ($past(i_core_addr[15:14]) != 2'h3)) else $error("select wrong at 16K");
  a_sel_48k: assert property (ext_on && i_flash_alloc == 2'h2 && i_core_addr[15:14] == 2'h1 |=>
    o_port_k_out[7] == $past(i_rom_half_map)) else $error("select wrong at 48K");
  a_sel_64k: assert property (ext_on && i_flash_alloc == 2'h3 && !i_core_addr[15] |=>
    o_port_k_out[7] == $past(i_rom_half_map)) else $error("select wrong at 64K");
  a_gpio_low: assert property (!ext_on |=>
    o_port_k_out[5:0] == $past(i_gpio_port_k_out[5:0])) else $error("port bits not gpio");
  a_gpio_sel: assert property (!i_emulate_port_k |=>
    o_port_k_out[7] == $past(i_gpio_port_k_out[7])) else $error("bit 7 not gpio");
  a_call_steps: assert property (call_go |=>
    o_program_page_select == ($past(i_call_indirect) ? $past(i_call_ind_page) : $past(i_call_imm_page))
    ##1 o_push && o_push_data == $past(i_call_ret_addr, 2)
    ##1 o_push && o_push_data == {10'h000, $past(o_program_page_select, 3)} ##1 o_queue_refill)
    else $error("far call steps wrong");
  a_rtc_steps: assert property (i_rtc_start && !call_go && !o_seq_busy |=>
    o_pull ##1 o_pull ##2 o_pc_load ##2 o_queue_refill) else $error("far return steps wrong");
  a_irq_block: assert property (call_go |=> o_irq_block [*3]) else $error("interrupts not blocked");
  a_reg_read: assert property (i_reg_rd |=>
    o_reg_rdata == $past(o_program_page_select)) else $error("read data wrong");

  c_call: cover property (call_go);
  c_rtc: cover property (i_rtc_start && !o_seq_busy);
  c_win: cover property (ext_on && i_core_addr[15:14] == 2'h2);
endmodule

bind ppx_page_ext ppx_page_ext_chk #(.PAGE_W(PAGE_W)) u_chk (
  .i_clk(i_clk), .i_srst(i_srst), .i_reg_rd(i_reg_rd), .i_call_start(i_call_start),
  .i_rtc_start(i_rtc_start), .i_call_indirect(i_call_indirect), .i_call_imm_page(i_call_imm_page),
  .i_call_ind_page(i_call_ind_page), .i_call_ret_addr(i_call_ret_addr), .i_core_addr(i_core_addr),
  .i_expanded_mode(i_expanded_mode), .i_emulate_port_k(i_emulate_port_k), .i_flash_alloc(i_flash_alloc),
  .i_rom_half_map(i_rom_half_map), .i_gpio_port_k_out(i_gpio_port_k_out), .o_port_k_out(o_port_k_out),
  .o_reg_rdata(o_reg_rdata), .o_push(o_push), .o_pull(o_pull), .o_push_data(o_push_data),
  .o_pc_load(o_pc_load), .o_queue_refill(o_queue_refill), .o_seq_busy(o_seq_busy),
  .o_irq_block(o_irq_block), .o_program_page_select(o_program_page_select)
);

// ### dv/ppx_page_ext_tb.sv
`timescale 1ns/100ps
module ppx_page_ext_tb;
  typedef struct packed {
    logic [1:0]  al;
    logic        hm;
    logic [1:0]  sw;
    logic [5:0]  pg;
    logic [15:0] ad;
    logic        sel;
    logic [5:0]  xa;
  } ppx_row_t;
  logic        i_clk, i_srst, i_reg_wr, i_reg_rd, i_call_start, i_rtc_start, i_call_indirect, seen;
  logic [5:0]  i_reg_wdata, i_call_imm_page, i_call_ind_page, o_reg_rdata, o_program_page_select;
  logic [15:0] i_call_ret_addr, i_pull_data, o_push_data, o_pc_value, i_core_addr;
  logic        o_push, o_pull, o_pc_load, o_queue_refill, o_seq_busy, o_irq_block, o_page_internal;
  logic        i_expanded_mode, i_emulate_port_k, i_rom_half_map;
  logic [1:0]  i_flash_alloc, i_paging_config_switches;
  logic [7:0]  i_gpio_port_k_out, i_gpio_port_k_oe, o_port_k_out, o_port_k_oe;
  int          n_errors, total_checks, cyc;
  ppx_row_t    rows [0:17];

  ppx_page_ext #(.PAGE_W(6)) uut (
    .i_clk(i_clk), .i_srst(i_srst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_call_start(i_call_start), .i_rtc_start(i_rtc_start),
    .i_call_imm_page(i_call_imm_page), .i_call_indirect(i_call_indirect), .i_call_ind_page(i_call_ind_page),
    .i_call_ret_addr(i_call_ret_addr), .o_push(o_push), .o_pull(o_pull), .o_push_data(o_push_data),
    .i_pull_data(i_pull_data), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_queue_refill(o_queue_refill),
    .o_seq_busy(o_seq_busy), .o_irq_block(o_irq_block), .i_core_addr(i_core_addr),
    .i_expanded_mode(i_expanded_mode), .i_emulate_port_k(i_emulate_port_k), .i_flash_alloc(i_flash_alloc),
    .i_rom_half_map(i_rom_half_map), .i_paging_config_switches(i_paging_config_switches),
    .i_gpio_port_k_out(i_gpio_port_k_out), .i_gpio_port_k_oe(i_gpio_port_k_oe), .o_port_k_out(o_port_k_out),
    .o_port_k_oe(o_port_k_oe), .o_program_page_select(o_program_page_select), .o_page_internal(o_page_internal)
  );
  ppx_stack_model u_stk (
    .i_clk(i_clk), .i_srst(i_srst), .i_push(o_push), .i_pull(o_pull), .i_push_data(o_push_data),
    .o_pull_data(i_pull_data)
  );

  // 8 ns clock
  initial begin
    i_clk = 1'h0;
    forever #4 i_clk = ~i_clk;
  end

  // hang guard; the whole run needs about 130 cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // one-cycle write strobe, entered just after an edge
  task automatic reg_wr(input logic [5:0] v);
    i_reg_wr    <= 1'h1;
    i_reg_wdata <= v;
    @(posedge i_clk);
    i_reg_wr    <= 1'h0;
  endtask

  // the unused page source gets a decoy so a wrong pick shows
  task automatic far_call(input logic ind, input logic [5:0] pg, input logic [15:0] ra);
    i_call_start    <= 1'h1;
    i_call_indirect <= ind;
    i_call_imm_page <= ind ? 6'h11 : pg;
    i_call_ind_page <= ind ? pg : 6'h11;
    i_call_ret_addr <= ra;
    @(posedge i_clk);
    i_call_start <= 1'h0;
    reg_wr(6'h3F);
    repeat (5) @(posedge i_clk);
    #1 chk(o_program_page_select, pg);
    @(posedge i_clk);
  endtask

  task automatic far_ret(input logic [5:0] pg, input logic [15:0] ra);
    seen = 1'h0;
    i_rtc_start <= 1'h1;
    @(posedge i_clk);
    i_rtc_start <= 1'h0;
    repeat (8) begin
      @(posedge i_clk);
      #1 if (o_pc_load === 1'h1) begin
        seen = 1'h1;
        chk(o_pc_value, ra);
      end
    end
    chk(seen, 1'h1);
    chk(o_program_page_select, pg);
    @(posedge i_clk);
  endtask

  initial begin
    i_srst = 1'h1;
    {i_reg_wr, i_reg_rd, i_call_start, i_rtc_start, i_call_indirect, i_reg_wdata, i_call_imm_page} = '0;
    {i_call_ind_page, i_call_ret_addr, i_core_addr, i_expanded_mode, i_emulate_port_k} = '0;
    {i_rom_half_map, i_flash_alloc, i_paging_config_switches, i_gpio_port_k_out, i_gpio_port_k_oe} = '0;
    // alloc, half map, switches, page, address, select, extended address
    rows = '{'{2'h0,1'h0,2'h0,6'h15,16'h1000,1'h1,6'h3D}, '{2'h0,1'h0,2'h0,6'h15,16'h5000,1'h1,6'h3E},
             '{2'h0,1'h0,2'h0,6'h15,16'h9000,1'h0,6'h15}, '{2'h0,1'h0,2'h0,6'h15,16'hC000,1'h0,6'h3F},
             '{2'h1,1'h0,2'h0,6'h2A,16'hBFFF,1'h1,6'h2A}, '{2'h1,1'h0,2'h0,6'h2A,16'hFFFF,1'h0,6'h3F},
             '{2'h2,1'h0,2'h0,6'h2A,16'h4000,1'h0,6'h3E}, '{2'h2,1'h1,2'h0,6'h2A,16'h7FFF,1'h1,6'h3E},
             '{2'h2,1'h0,2'h0,6'h2A,16'h0000,1'h1,6'h3D}, '{2'h2,1'h0,2'h0,6'h38,16'h8000,1'h0,6'h38},
             '{2'h2,1'h0,2'h0,6'h37,16'h8000,1'h1,6'h37}, '{2'h3,1'h1,2'h1,6'h30,16'hA000,1'h0,6'h30},
             '{2'h3,1'h1,2'h1,6'h2F,16'hA000,1'h1,6'h2F}, '{2'h3,1'h0,2'h2,6'h20,16'h8000,1'h0,6'h20},
             '{2'h3,1'h0,2'h2,6'h1F,16'h8000,1'h1,6'h1F}, '{2'h3,1'h1,2'h3,6'h00,16'h8000,1'h0,6'h00},
             '{2'h3,1'h0,2'h3,6'h00,16'h3FFF,1'h0,6'h3D}, '{2'h3,1'h1,2'h0,6'h00,16'h0000,1'h1,6'h3D}};
    repeat (6) @(posedge i_clk);
    i_srst <= 1'h0;
    @(posedge i_clk);
    #1 chk(o_program_page_select, 6'h00);
    chk(o_port_k_oe, 8'h00);
    @(posedge i_clk);
    i_expanded_mode  <= 1'h1;
    i_emulate_port_k <= 1'h1;
    // decode table, page written in the same cycle each address is applied
    foreach (rows[k]) begin
      i_flash_alloc            <= rows[k].al;
      i_rom_half_map           <= rows[k].hm;
      i_paging_config_switches <= rows[k].sw;
      i_core_addr              <= rows[k].ad;
      reg_wr(rows[k].pg);
      repeat (2) @(posedge i_clk);
      #1 chk(o_port_k_out[7], rows[k].sel);
      chk(o_port_k_out[5:0], rows[k].xa);
      chk(o_page_internal, {1'h0, rows[k].pg} >= 7'h40 - (7'h08 << rows[k].sw));
      @(posedge i_clk);
    end
    // write then read with no gap
    reg_wr(6'h2A);
    i_reg_rd <= 1'h1;
    @(posedge i_clk);
    i_reg_rd <= 1'h0;
    #1 chk(o_reg_rdata, 6'h2A);
    @(posedge i_clk);
    i_gpio_port_k_out <= 8'hA5;
    i_gpio_port_k_oe  <= 8'hC3;
    i_emulate_port_k  <= 1'h0;
    repeat (2) @(posedge i_clk);
    #1 chk(o_port_k_out, 8'hA5);
    chk(o_port_k_oe, 8'hC3);
    @(posedge i_clk);
    i_gpio_port_k_out <= 8'h5A;
    i_emulate_port_k  <= 1'h1;
    i_expanded_mode   <= 1'h0;
    repeat (2) @(posedge i_clk);
    #1 chk(o_port_k_out[5:0], 6'h1A);
    chk(o_port_k_out[7], 1'h1);
    @(posedge i_clk);
    i_expanded_mode <= 1'h1;
    // nested calls unwind in reverse order
    reg_wr(6'h05);
    far_call(1'h0, 6'h21, 16'h1234);
    far_call(1'h1, 6'h33, 16'hBEEF);
    far_ret(6'h21, 16'hBEEF);
    far_ret(6'h05, 16'h1234);
    print_verdict();
  end
endmodule

// ### dv/ppx_stack_model.sv
`timescale 1ns/100ps
module ppx_stack_model (
  // clock and reset
  input  wire         i_clk,
  input  wire         i_srst,
  // stack port
  input  wire         i_push,
  input  wire         i_pull,
  input  wire  [15:0] i_push_data,
  output logic [15:0] o_pull_data
);
  logic [15:0] mem_ff [0:15];
  logic [3:0]  sp_ff;
  // lifo; pulled data stands one cycle, then scrambles so stale reads show up
  always @(posedge i_clk) begin
    if (i_srst) begin
      sp_ff       <= 4'h0;
      o_pull_data <= 16'h5A5A;
    end else if (i_push) begin
      mem_ff[sp_ff] <= i_push_data;
      sp_ff         <= sp_ff + 4'h1;
      o_pull_data   <= ~o_pull_data;
    end else if (i_pull) begin
      o_pull_data <= mem_ff[sp_ff - 4'h1];
      sp_ff       <= sp_ff - 4'h1;
    end else begin
      o_pull_data <= ~o_pull_data;
    end
  end
endmodule

// ### src/ppx_map.vh
`ifndef PPX_MAP_VH
`define PPX_MAP_VH

// page select and page index width
`define PPX_PAGE_W        6
// extended address constants outside the window
`define PPX_XA_LOW        6'h3D
`define PPX_XA_MID        6'h3E
`define PPX_XA_TOP        6'h3F
// 16K range codes, from address bits 15:14
`define PPX_RNG_LOW       2'h0
`define PPX_RNG_MID       2'h1
`define PPX_RNG_WIN       2'h2
`define PPX_RNG_TOP       2'h3
// allocated flash/rom size codes
`define PPX_ALLOC_0K      2'h0
`define PPX_ALLOC_16K     2'h1
`define PPX_ALLOC_48K     2'h2
`define PPX_ALLOC_64K     2'h3
// paging configuration switch settings
`define PPX_PSW_128K      2'h0
`define PPX_PSW_256K      2'h1
`define PPX_PSW_512K      2'h2
`define PPX_PSW_1M        2'h3
// lowest internal page for each switch setting below 1M
`define PPX_INT_128K      6'h38
`define PPX_INT_256K      6'h30
`define PPX_INT_512K      6'h20
// page select reset value
`define PPX_PAGE_RST      6'h00
// sequencer states
`define PPX_ST_IDLE       3'h0
`define PPX_ST_C_PUSHRA   3'h1
`define PPX_ST_C_PUSHPG   3'h2
`define PPX_ST_C_FILL     3'h3
`define PPX_ST_R_PULLPG   3'h4
`define PPX_ST_R_PULLRA   3'h5
`define PPX_ST_R_LOADPG   3'h6
`define PPX_ST_R_FILL     3'h7

`endif

// ### src/ppx_page_ext.v
// How it works
// R1 - far call saves old page to holding register and loads new page on the same edge
// R2 - far call then pushes 16-bit return address, then old page, then refills
// R3 - far call and far return sequences block interrupts between their steps
// R4 - page select picks one of 64 pages for the 16K window
// R5 - new page is immediate, or fetched through pointer for indexed-indirect forms
// R6 - far return pulls page, pulls return address to PC, writes page, refills
// R7 - window access in expanded mode with emulation bit drives page index out
// R8 - outside window extended address is 0x3D, 0x3E or 0x3F by range
// R9 - 0K allocation: select high below 0x8000, low for window and top
// R10 - 16K allocation: select low only for top range
// R11 - 48K: mid range low when half-map clear, window low if internal
// R12 - 64K: both low ranges low when half-map clear, window low if internal
// R13 - extended address and select shown only in expanded mode with emulation bit
// R14 - internal pages follow paging switches: 0x38, 0x30, 0x20 upward, or all
// R15 - with emulation bit set port K bit 7 is emulation select, else GPIO
// R16 - emulation bit clear or not expanded: port K 5:0 stay ordinary GPIO
`timescale 1ns/100ps
`include "ppx_map.vh"

module ppx_page_ext #(
  parameter PAGE_W = `PPX_PAGE_W
) (
  // clock and reset
  input  wire              i_clk,
  input  wire              i_srst,
  // register port for the page select register
  input  wire              i_reg_wr,
  input  wire              i_reg_rd,
  input  wire [PAGE_W-1:0] i_reg_wdata,
  output wire [PAGE_W-1:0] o_reg_rdata,
  // far call / far return requests from the core
  input  wire              i_call_start,
  input  wire              i_rtc_start,
  input  wire [PAGE_W-1:0] i_call_imm_page,
  input  wire              i_call_indirect,
  input  wire [PAGE_W-1:0] i_call_ind_page,
  input  wire [15:0]       i_call_ret_addr,
  // stack port
  output wire              o_push,
  output wire              o_pull,
  output wire [15:0]       o_push_data,
  input  wire [15:0]       i_pull_data,
  // program counter load and queue refill
  output wire              o_pc_load,
  output wire [15:0]       o_pc_value,
  output wire              o_queue_refill,
  output wire              o_seq_busy,
  output wire              o_irq_block,
  // core address and mode
  input  wire [15:0]       i_core_addr,
  input  wire              i_expanded_mode,
  input  wire              i_emulate_port_k,
  input  wire [1:0]        i_flash_alloc,
  input  wire              i_rom_half_map,
  input  wire [1:0]        i_paging_config_switches,
  // port K general-purpose drive
  input  wire [7:0]        i_gpio_port_k_out,
  input  wire [7:0]        i_gpio_port_k_oe,
  // port K pins
  output wire [7:0]        o_port_k_out,
  output wire [7:0]        o_port_k_oe,
  output wire [PAGE_W-1:0] o_program_page_select,
  output wire              o_page_internal
);

  reg [PAGE_W-1:0] program_page_select_ff;
  reg [PAGE_W-1:0] nxt_program_page_select;
  reg [PAGE_W-1:0] hold_page_ff;
  reg [PAGE_W-1:0] nxt_hold_page;
  reg [2:0]        state_ff;
  reg [2:0]        nxt_state;
  reg [PAGE_W-1:0] pulled_page_ff;
  reg [PAGE_W-1:0] nxt_pulled_page;
  reg [15:0]       ret_addr_ff;
  reg [15:0]       nxt_ret_addr;
  reg              push_ff;
  reg              nxt_push;
  reg              pull_ff;
  reg              nxt_pull;
  reg [15:0]       push_data_ff;
  reg [15:0]       nxt_push_data;
  reg              pc_load_ff;
  reg              nxt_pc_load;
  reg [15:0]       pc_value_ff;
  reg [15:0]       nxt_pc_value;
  reg              refill_ff;
  reg              nxt_refill;
  reg [PAGE_W-1:0] rdata_ff;
  reg [7:0]        port_k_out_ff;
  reg [7:0]        port_k_oe_ff;
  reg              page_int_ff;
  reg              busy_ff;

  // page index is internal when at or above the switch threshold
  function is_internal;
    input [1:0]        psw;
    input [PAGE_W-1:0] pix;
    begin
      case (psw)
        `PPX_PSW_128K: is_internal = (pix >= `PPX_INT_128K);  // R14
        `PPX_PSW_256K: is_internal = (pix >= `PPX_INT_256K);  // R14
        `PPX_PSW_512K: is_internal = (pix >= `PPX_INT_512K);  // R14
        default:       is_internal = 1'b1;                    // R14
      endcase
    end
  endfunction

  // sequencer step plan, one state per clock
  // idle: waits for a call or return start
  //   a call start wins over a return start
  //   a software write only lands while idle
  // far call, c0 is the start edge
  //   c0: old page to holding register
  //   c0: new page loaded, busy rises
  //   c1: push of the return address
  //   c2: push of the old page, zero-extended
  //   c3: queue refill pulse, busy falls
  // far return, r0 is the start edge
  //   r0: first pull pulse raised
  //   r1: second pull pulse raised
  //   r2: first pulled word holds the page
  //   r3: second pulled word loads the pc
  //   r4: saved page written to page select
  //   r5: queue refill pulse, busy falls
  // stack timing assumed by the steps
  //   pulled data stands in the cycle after a pull
  //   pushes carry their data beside the pulse
  //   no wait states; the stack must keep pace
  // interrupt blocking
  //   busy is high from the start edge to the refill
  //   the core must hold interrupts while busy
  //   so no step can be split by an exception
  // limitations
  //   starts during a sequence are ignored
  //   a write during a sequence is dropped silently
  //   stack pointer handling is left to the core
  //   return address arithmetic is left to the core
  // why the return pulls twice before sampling
  //   each answer lags its pull by one cycle
  //   sampling at the pull itself reads stale data
  //   the refill state is shared by both sequences
  //   which keeps the state code at three bits
  // pin side
  //   bits 5:0 carry the page in the window
  //   and a fixed code outside it
  //   bit 7 carries the active-low select
  //   bit 6 stays ordinary port drive
  //   all pin outputs are registered one cycle late
  //   select follows the current page, not a pending one
  // decode side
  //   the range comes from address bits 15:14
  //   for 48K and 64K, window select depends on the internal test
  //   the internal test follows the paging switches
  //   half-map only matters for 48K and 64K
  //   not expanded forces the select pin high

  // sequencer for far call and far return
  always @* begin
    nxt_state               = state_ff;
    nxt_program_page_select = program_page_select_ff;
    nxt_hold_page           = hold_page_ff;
    nxt_pulled_page         = pulled_page_ff;
    nxt_ret_addr            = ret_addr_ff;
    nxt_push                = 1'b0;
    nxt_pull                = 1'b0;
    nxt_push_data           = push_data_ff;
    nxt_pc_load             = 1'b0;
    nxt_pc_value            = pc_value_ff;
    nxt_refill              = 1'b0;
    case (state_ff)
      `PPX_ST_IDLE: begin
        if (i_call_start) begin
          nxt_hold_page = program_page_select_ff;  // R1
          // indirect forms carry the page fetched via pointer
          nxt_program_page_select = i_call_indirect ? i_call_ind_page : i_call_imm_page;  // R1 R5
          nxt_ret_addr  = i_call_ret_addr;
          nxt_state     = `PPX_ST_C_PUSHRA;
        end else if (i_rtc_start) begin
          nxt_pull  = 1'b1;  // R6
          nxt_state = `PPX_ST_R_PULLPG;
        end else if (i_reg_wr) begin
          // software write loses to a sequence start in the same cycle
          nxt_program_page_select = i_reg_wdata;  // R4
        end
      end
      `PPX_ST_C_PUSHRA: begin
        nxt_push      = 1'b1;  // R2
        nxt_push_data = ret_addr_ff;
        nxt_state     = `PPX_ST_C_PUSHPG;
      end
      `PPX_ST_C_PUSHPG: begin
        nxt_push      = 1'b1;  // R2
        nxt_push_data = {{(16-PAGE_W){1'b0}}, hold_page_ff};
        nxt_state     = `PPX_ST_C_FILL;
      end
      `PPX_ST_C_FILL: begin
        nxt_refill = 1'b1;  // R2
        nxt_state  = `PPX_ST_IDLE;
      end
      `PPX_ST_R_PULLPG: begin
        // stack answers each pull one cycle after its pulse
        nxt_pull  = 1'b1;  // R6
        nxt_state = `PPX_ST_R_PULLRA;
      end
      `PPX_ST_R_PULLRA: begin
        nxt_pulled_page = i_pull_data[PAGE_W-1:0];  // R6
        nxt_state       = `PPX_ST_R_LOADPG;
      end
      `PPX_ST_R_LOADPG: begin
        nxt_pc_load  = 1'b1;  // R6
        nxt_pc_value = i_pull_data;
        nxt_state    = `PPX_ST_R_FILL;
      end
      `PPX_ST_R_FILL: begin
        // page written after the pc; shared refill step follows
        nxt_program_page_select = pulled_page_ff;  // R6
        nxt_state               = `PPX_ST_C_FILL;
      end
      default: nxt_state = `PPX_ST_IDLE;
    endcase
  end

  // sequencer registers
  always @(posedge i_clk) begin
    if (i_srst) begin
      state_ff               <= `PPX_ST_IDLE;
      program_page_select_ff <= `PPX_PAGE_RST;
      hold_page_ff           <= `PPX_PAGE_RST;
      pulled_page_ff         <= `PPX_PAGE_RST;
      ret_addr_ff            <= 16'h0000;
      push_ff                <= 1'b0;
      pull_ff                <= 1'b0;
      push_data_ff           <= 16'h0000;
      pc_load_ff             <= 1'b0;
      pc_value_ff            <= 16'h0000;
      refill_ff              <= 1'b0;
      busy_ff                <= 1'b0;
      rdata_ff               <= `PPX_PAGE_RST;
    end else begin
      state_ff               <= nxt_state;
      program_page_select_ff <= nxt_program_page_select;
      hold_page_ff           <= nxt_hold_page;
      pulled_page_ff         <= nxt_pulled_page;
      ret_addr_ff            <= nxt_ret_addr;
      push_ff                <= nxt_push;
      pull_ff                <= nxt_pull;
      push_data_ff           <= nxt_push_data;
      pc_load_ff             <= nxt_pc_load;
      pc_value_ff            <= nxt_pc_value;
      refill_ff              <= nxt_refill;
      // busy covers every step so interrupts wait for the whole sequence
      busy_ff                <= (nxt_state != `PPX_ST_IDLE);  // R3
      if (i_reg_rd) begin
        rdata_ff <= program_page_select_ff;
      end
    end
  end

  // external address and emulation select decode
  reg [1:0]        rng;
  reg [PAGE_W-1:0] xa;
  reg              sel_n;
  reg              win_int;
  reg              show;
  always @* begin
    rng     = i_core_addr[15:14];
    win_int = is_internal(i_paging_config_switches, program_page_select_ff);
    show    = i_expanded_mode & i_emulate_port_k;  // R13
    case (rng)
      `PPX_RNG_LOW: xa = `PPX_XA_LOW;              // R8
      `PPX_RNG_MID: xa = `PPX_XA_MID;              // R8
      `PPX_RNG_WIN: xa = program_page_select_ff;   // R7
      default:      xa = `PPX_XA_TOP;              // R8
    endcase
    sel_n = 1'b1;
    case (i_flash_alloc)
      `PPX_ALLOC_0K:  sel_n = (rng == `PPX_RNG_LOW) | (rng == `PPX_RNG_MID);  // R9
      `PPX_ALLOC_16K: sel_n = (rng != `PPX_RNG_TOP);                          // R10
      `PPX_ALLOC_48K: begin
        case (rng)
          `PPX_RNG_MID: sel_n = i_rom_half_map;  // R11
          `PPX_RNG_WIN: sel_n = ~win_int;        // R11
          `PPX_RNG_TOP: sel_n = 1'b0;            // R11
          default:      sel_n = 1'b1;            // R11
        endcase
      end
      default: begin
        case (rng)
          `PPX_RNG_WIN: sel_n = ~win_int;        // R12
          `PPX_RNG_TOP: sel_n = 1'b0;            // R12
          default:      sel_n = i_rom_half_map;  // R12
        endcase
      end
    endcase
  end

  // port K muxing, registered so pins come from flip-flops
  always @(posedge i_clk) begin
    if (i_srst) begin
      port_k_out_ff <= 8'h00;
      port_k_oe_ff  <= 8'h00;
      page_int_ff   <= 1'b0;
    end else begin
      page_int_ff <= win_int;
      // bit 6 stays GPIO here; the external select lives elsewhere
      port_k_out_ff[6] <= i_gpio_port_k_out[6];
      port_k_oe_ff[6]  <= i_gpio_port_k_oe[6];
      if (i_emulate_port_k) begin
        port_k_out_ff[7] <= sel_n | ~i_expanded_mode;  // R15 R13
        port_k_oe_ff[7]  <= 1'b1;                      // R15
      end else begin
        port_k_out_ff[7] <= i_gpio_port_k_out[7];      // R15
        port_k_oe_ff[7]  <= i_gpio_port_k_oe[7];       // R15
      end
      if (show) begin
        port_k_out_ff[5:0] <= xa;                      // R7 R13
        port_k_oe_ff[5:0]  <= 6'h3F;
      end else begin
        port_k_out_ff[5:0] <= i_gpio_port_k_out[5:0];  // R16
        port_k_oe_ff[5:0]  <= i_gpio_port_k_oe[5:0];   // R16
      end
    end
  end

  // outputs
  assign o_reg_rdata           = rdata_ff;
  assign o_push                = push_ff;
  assign o_pull                = pull_ff;
  assign o_push_data           = push_data_ff;
  assign o_pc_load             = pc_load_ff;
  assign o_pc_value            = pc_value_ff;
  assign o_queue_refill        = refill_ff;
  assign o_seq_busy            = busy_ff;
  assign o_irq_block           = busy_ff;  // R3
  assign o_port_k_out          = port_k_out_ff;
  assign o_port_k_oe           = port_k_oe_ff;
  assign o_program_page_select = program_page_select_ff;  // R4
  assign o_page_internal       = page_int_ff;

endmodule
